// file: qdo_pkg.sv
`default_nettype none
package qdo_pkg;
  localparam int unsigned NUM_POINTS   = 16;
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned CODE_W       = 12;
  localparam int unsigned LO_BYTE_W    = 8;
  localparam int unsigned HI_CODE_W    = 4;
  localparam int unsigned SEL_LSB      = 12;
  localparam logic [11:0] CODE_RST     = 12'h000;
  localparam logic [11:0] CODE_FULL    = 12'hFFF;
  localparam logic [3:0]  SEL_NONE     = 4'h0;

  // range code per channel
  typedef enum logic [1:0] {
    QDO_RANGE_10V = 2'b00,
    QDO_RANGE_5V  = 2'b01
  } qdo_range_t;

  localparam qdo_range_t RANGE_RST = QDO_RANGE_10V;
endpackage
`default_nettype wire

// file: qdo_code_mem.sv
`timescale 1ns/1ns
`default_nettype none
// holds the latched code of each channel; read data come straight from the entries, with no read register
module qdo_code_mem #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned WIDTH = 12
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic [DEPTH-1:0]         wr_en_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  output logic      [DEPTH*WIDTH-1:0]   rd_data_o
);
  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_comb begin
        mem_next[g] = wr_en_i[g] ? wr_data_i : mem_reg[g];
      end
      always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
          mem_reg[g] <= WIDTH'(qdo_pkg::CODE_RST);
        end else begin
          mem_reg[g] <= mem_next[g];
        end
      end
      assign rd_data_o[g*WIDTH +: WIDTH] = mem_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire

// file: qdo_output_port.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - occupies sixteen output image points
// - at most one channel updated per scan
// - top four points select channels 1..4
// - twelve points form unsigned binary code
// - code 0..FFF maps linearly over range
// - per-channel range 0-5V or 4-12mA selectable
// - default range 0-10V / 4-20mA
module qdo_output_port #(
  parameter int unsigned NUM_CH = qdo_pkg::NUM_CH,
  parameter int unsigned CODE_W = qdo_pkg::CODE_W
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic [15:0]               image_i,
  input  wire logic                      scan_strobe_i,
  input  wire logic [NUM_CH-1:0]         range_half_i,
  output logic      [NUM_CH*CODE_W-1:0]  dac_code_o,
  output logic      [NUM_CH-1:0]         range_half_o,
  output logic      [NUM_CH-1:0]         update_o,
  output logic                           sel_error_o
);
  logic [CODE_W-1:0] code_w;
  logic [NUM_CH-1:0] sel_w;
  logic              one_hot_w;
  logic [NUM_CH-1:0] wr_en_w;
  logic [NUM_CH-1:0] range_reg;
  logic [NUM_CH-1:0] range_next;
  logic [NUM_CH-1:0] upd_reg;
  logic [NUM_CH-1:0] upd_next;
  logic              err_reg;
  logic              err_next;

  always_comb begin
    // code bits 7:0 from low byte, 11:8 from low nibble of high byte
    code_w    = image_i[CODE_W-1:0];
    sel_w     = image_i[qdo_pkg::SEL_LSB +: NUM_CH];
    one_hot_w = (sel_w != '0) && ((sel_w & (sel_w - 1'b1)) == '0);
    // several select lines in one scan update nothing
    wr_en_w   = (scan_strobe_i && one_hot_w) ? sel_w : '0;
    upd_next  = wr_en_w;
    err_next  = scan_strobe_i && !one_hot_w && (sel_w != '0);
    range_next = range_half_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      range_reg <= {NUM_CH{qdo_pkg::RANGE_RST == qdo_pkg::QDO_RANGE_5V}};
      upd_reg   <= '0;
      err_reg   <= 1'b0;
    end else begin
      range_reg <= range_next;
      upd_reg   <= upd_next;
      err_reg   <= err_next;
    end
  end

  // code is passed unchanged to the converter: linear, 0 low, FFF high
  qdo_code_mem #(
    .DEPTH (NUM_CH),
    .WIDTH (CODE_W)
  ) u_mem (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .wr_en_i   (wr_en_w),
    .wr_data_i (code_w),
    .rd_data_o (dac_code_o)
  );

  assign range_half_o = range_reg;
  assign update_o     = upd_reg;
  assign sel_error_o  = err_reg;

  a_one_update: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $onehot0(update_o)) else $error("more than one channel updated");

  a_sel_latch: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (scan_strobe_i && image_i[15:12] == 4'h4) |=>
      update_o == 4'h4 && dac_code_o[35:24] == $past(image_i[11:0]))
    else $error("channel 3 did not latch code");

  a_hold_value: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !scan_strobe_i |=> $stable(dac_code_o)) else $error("output changed without scan");

  a_code_ch1: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (scan_strobe_i && image_i[15:12] == 4'h1) |=>
      dac_code_o[11:0] == $past(image_i[11:0])) else $error("channel 1 code wrong");

  a_multi_sel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (scan_strobe_i && image_i[15:12] == 4'h3) |=> update_o == 4'h0 && sel_error_o)
    else $error("multi select not refused");

  a_range_follow: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    1'b1 |=> range_half_o == $past(range_half_i)) else $error("range not followed");

  a_reset_range: assert property (@(posedge sys_clk_i)
    !nrst_i |=> range_half_o == 4'h0 && dac_code_o == '0) else $error("reset default wrong");

  a_no_sel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (scan_strobe_i && image_i[15:12] == 4'h0) |=> update_o == 4'h0 && !sel_error_o)
    else $error("update without select");

  // scan shapes and answers shared by the properties below
  sequence s_one_sel;
    scan_strobe_i && $onehot(image_i[qdo_pkg::SEL_LSB +: NUM_CH]);
  endsequence

  sequence s_many_sel;
    scan_strobe_i && !$onehot0(image_i[qdo_pkg::SEL_LSB +: NUM_CH]);
  endsequence

  sequence s_quiet_scan;
    !scan_strobe_i || (image_i[qdo_pkg::SEL_LSB +: NUM_CH] == qdo_pkg::SEL_NONE);
  endsequence

  sequence s_answer_one;
    $onehot(update_o) && !sel_error_o;
  endsequence

  sequence s_answer_none;
    (update_o == '0) && !sel_error_o;
  endsequence

  sequence s_answer_refused;
    (update_o == '0) && sel_error_o;
  endsequence

  property p_single_answer;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_one_sel |=> s_answer_one;
  endproperty

  a_single_answer: assert property (p_single_answer)
    else $error("single select did not give one update");

  property p_upd_map;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_one_sel |=> update_o == $past(image_i[qdo_pkg::SEL_LSB +: NUM_CH]);
  endproperty

  a_upd_map: assert property (p_upd_map)
    else $error("update bit does not match select line");

  property p_many_refused;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_many_sel |=> s_answer_refused ##0 $stable(dac_code_o);
  endproperty

  a_many_refused: assert property (p_many_refused)
    else $error("several select lines were not refused");

  property p_quiet_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_quiet_scan |=> s_answer_none ##0 $stable(dac_code_o);
  endproperty

  a_quiet_hold: assert property (p_quiet_hold)
    else $error("output moved without a selected channel");

  property p_write_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_one_sel ##1 s_quiet_scan |=> $stable(dac_code_o);
  endproperty

  a_write_hold: assert property (p_write_hold)
    else $error("written code not held over an idle scan");

  property p_err_once;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_many_sel ##1 s_quiet_scan |=> s_answer_none;
  endproperty

  a_err_once: assert property (p_err_once)
    else $error("error pulse lasted too long");

  property p_refuse_recover;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_many_sel ##1 s_one_sel |=> s_answer_one;
  endproperty

  a_refuse_recover: assert property (p_refuse_recover)
    else $error("scan after a refusal was not taken");

  a_err_cause: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    sel_error_o |-> $past(scan_strobe_i) && !$onehot0($past(sel_w)))
    else $error("error pulse without a multiple select");

  a_upd_cause: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (update_o != '0) |-> $past(scan_strobe_i) && $onehot($past(sel_w)))
    else $error("update pulse without a single select");

  a_err_excl: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    sel_error_o |-> update_o == '0) else $error("error and update together");

  a_reset_pulse: assert property (@(posedge sys_clk_i)
    !nrst_i |=> update_o == '0 && !sel_error_o) else $error("pulse survived reset");

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch_chk
      a_ch_latch: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (scan_strobe_i && sel_w == NUM_CH'(1 << c)) |=>
          update_o[c] && dac_code_o[c*CODE_W +: CODE_W] == $past(image_i[CODE_W-1:0]))
        else $error("selected channel did not take the code");

      a_ch_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !(scan_strobe_i && sel_w == NUM_CH'(1 << c)) |=>
          $stable(dac_code_o[c*CODE_W +: CODE_W]))
        else $error("unselected channel changed its code");

      a_ch_upd: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        update_o[c] |-> $past(scan_strobe_i) && ($past(sel_w) == NUM_CH'(1 << c)))
        else $error("channel update without its select line");

      a_ch_range: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        1'b1 |=> range_half_o[c] == $past(range_half_i[c])) else $error("channel range lost");

      a_ch_full: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (scan_strobe_i && sel_w == NUM_CH'(1 << c) && code_w == qdo_pkg::CODE_FULL) |=>
          dac_code_o[c*CODE_W +: CODE_W] == qdo_pkg::CODE_FULL)
        else $error("full scale code not kept");

      a_ch_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (scan_strobe_i && sel_w == NUM_CH'(1 << c) && code_w == qdo_pkg::CODE_RST) |=>
          dac_code_o[c*CODE_W +: CODE_W] == qdo_pkg::CODE_RST)
        else $error("zero code not kept");
    end
  endgenerate
endmodule
`default_nettype wire

// file: qdo_host.sv
`timescale 1ns/1ns
`default_nettype none
// host side: writes one output image per scan, strobed for one cycle, then drives its complement with the strobe low
module qdo_host (
  input  wire logic        sys_clk_i,
  output logic      [15:0] image_o,
  output logic             strobe_o
);
  initial begin
    image_o = 16'h0000;
    strobe_o = 1'b0;
  end
  task automatic scan(input logic [3:0] sel, input logic [11:0] code);
    @(negedge sys_clk_i);
    image_o = {sel, code[11:8], code[7:0]};
    strobe_o = 1'b1;
    @(negedge sys_clk_i);
    image_o = ~image_o;
    strobe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  rng = 4'hF;
  logic [15:0] img;
  logic        stb;
  logic [47:0] code;
  logic [3:0]  rng_o;
  logic [3:0]  upd;
  logic        err;
  logic [47:0] exp_c = 48'h0;
  logic [13:0] rows [6] = '{14'h0ABC, 14'h1A5A, 14'h2FFF, 14'h3800, 14'h1000, 14'h0001};
  int          error_cnt = 0;
  int          n_tests = 0;
  always #5 clk = ~clk;
  qdo_host qdo_host_inst (.sys_clk_i(clk), .image_o(img), .strobe_o(stb));
  qdo_output_port qdo_output_port_inst (.sys_clk_i(clk), .nrst_i(nrst), .image_i(img),
    .scan_strobe_i(stb), .range_half_i(rng), .dac_code_o(code), .range_half_o(rng_o),
    .update_o(upd), .sel_error_o(err));
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    chk("code rst", 48'h0, code);
    chk("range rst", 48'h0, {44'h0, rng_o});
    rng = 4'h0;
    $display("reset test done");
    foreach (rows[i]) begin
      qdo_host_inst.scan(4'h1 << rows[i][13:12], rows[i][11:0]);
      exp_c[rows[i][13:12]*12 +: 12] = rows[i][11:0];
      chk("upd", {44'h0, 4'h1 << rows[i][13:12]}, {44'h0, upd});
      chk("code", exp_c, code);
    end
    $display("table test done");
    qdo_host_inst.scan(4'h3, 12'h555);
    chk("two sel", 48'h10, {43'h0, err, upd});
    chk("code held", exp_c, code);
    qdo_host_inst.scan(4'h0, 12'h555);
    chk("no sel", 48'h0, {43'h0, err, upd});
    chk("code held", exp_c, code);
    rng = 4'hA;
    @(negedge clk);
    chk("range", 48'hA, {44'h0, rng_o});
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    chk("code mid rst", 48'h0, code);
    chk("range mid rst", 48'h0, {44'h0, rng_o});
    qdo_host_inst.scan(4'h8, 12'h123);
    chk("code after rst", {12'h123, 36'h0}, code);
    chk("upd after rst", 48'h8, {44'h0, upd});
    $display("awkward test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
